// ### tpec_pkg.sv
// Shared constants, carrier types and decode helpers for the timer block.
package tpec_pkg;

  // ----------------------------------------------------------------
  // Mode register field positions
  // ----------------------------------------------------------------
  localparam logic [2:0] TA_MODE_PWM       = 3'b111;
  localparam int         MODE_PWM8_BIT     = 5;
  localparam int         MODE_EXT_TRIG_BIT = 4;
  localparam int         MODE_RISE_BIT     = 3;
  localparam int         MODE_SRC_LSB      = 6;
  localparam logic [1:0] TB_MODE_TIMER     = 2'b00;
  localparam logic [1:0] TB_MODE_EVENT     = 2'b01;
  localparam logic [1:0] TB_EDGE_FALL      = 2'b00;
  localparam logic [1:0] TB_EDGE_RISE      = 2'b01;
  localparam logic [1:0] TB_EDGE_BOTH      = 2'b10;

  // ----------------------------------------------------------------
  // Start flag layout, counts and reset values
  // ----------------------------------------------------------------
  localparam int          NUM_SRC       = 4;
  localparam int          NUM_TB        = 3;
  localparam int          START_TA_BIT  = 0;
  localparam int          START_TB_LSB  = 1;
  localparam int          SECOND_B      = 1;
  localparam int          THIRD_B       = 2;
  localparam logic [15:0] PWM16_LAST    = 16'hFFFE;
  localparam logic [7:0]  PWM8_LAST     = 8'hFE;
  localparam logic [15:0] TA_UNDEF_READ = 16'h0000;
  localparam logic [15:0] RELOAD_RST    = 16'h0000;
  localparam logic [15:0] CNT_ZERO      = 16'h0000;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] mode;
    logic       start;
  } tpec_tb_cfg_t;

  typedef struct packed {
    logic        wr;
    logic [15:0] data;
  } tpec_wr_t;

  typedef struct packed {
    logic        prev;
    logic [15:0] reload;
    logic [15:0] cnt;
    logic        irq;
  } tpec_tmb_state_t;

  typedef struct packed {
    logic              trg_s1;
    logic              trg_s2;
    logic              trg_prev;
    logic              run;
    logic [15:0]       reload;
    logic [15:0]       pos;
    logic [15:0]       width;
    logic [7:0]        psc;
    logic              out;
    logic              irq;
    logic [NUM_TB-1:0] ev_s1;
    logic [NUM_TB-1:0] ev_s2;
  } tpec_main_state_t;

  // Picks the count-source enable named by mode bits 7:6.
  function automatic logic tpec_src_sel(input logic [NUM_SRC-1:0] ce,
                                        input logic [7:0]         mode);
    tpec_src_sel = ce[mode[MODE_SRC_LSB+:2]];
  endfunction : tpec_src_sel

endpackage : tpec_pkg

// ### tpec_tmb_chan.sv
// One type-B down counter with timer and event counter modes.
`timescale 1ns/100ps
module tpec_tmb_chan
  import tpec_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  input  wire tpec_tb_cfg_t       cfg,
  input  wire logic [NUM_SRC-1:0] ce_src,
  input  wire logic               event_lvl,
  input  wire logic               alt_sel,
  input  wire logic               alt_tick,
  input  wire tpec_wr_t           wr,
  output logic [15:0]             cnt,
  output logic                    irq,
  output logic                    underflow
);

  tpec_tmb_state_t st_q;
  tpec_tmb_state_t st_d;
  logic            ev_edge;
  logic            tick;
  logic            is_event;

  // ----------------------------------------------------------------
  // Count source and edge selection
  // ----------------------------------------------------------------
  always_comb begin
    is_event = (cfg.mode[1:0] == TB_MODE_EVENT);
    case (cfg.mode[3:2])
      TB_EDGE_FALL: ev_edge = st_q.prev & ~event_lvl;
      TB_EDGE_RISE: ev_edge = ~st_q.prev & event_lvl;
      TB_EDGE_BOTH: ev_edge = st_q.prev ^ event_lvl;
      default:      ev_edge = 1'b0;
    endcase
    if (!cfg.start) begin
      tick = 1'b0;
    end else if (is_event && alt_sel) begin
      tick = alt_tick;
    end else if (is_event) begin
      tick = ev_edge;
    end else if (cfg.mode[1:0] == TB_MODE_TIMER) begin
      tick = tpec_src_sel(ce_src, cfg.mode);
    end else begin
      tick = 1'b0;
    end
  end

  assign underflow = tick && (st_q.cnt == CNT_ZERO);

  // ----------------------------------------------------------------
  // Counter and reload
  // ----------------------------------------------------------------
  always_comb begin
    st_d      = st_q;
    st_d.prev = event_lvl;
    st_d.irq  = 1'b0;
    if (wr.wr) begin
      st_d.reload = wr.data;
    end
    if (underflow) begin
      st_d.cnt = st_q.reload;
      st_d.irq = 1'b1;
    end else if (tick) begin
      st_d.cnt = st_q.cnt - 16'h0001;
    end
    if (wr.wr && !cfg.start) begin
      st_d.cnt = wr.data;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{prev: 1'b0, reload: RELOAD_RST, cnt: RELOAD_RST, irq: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // Counter is readable at any time; no pulse output or gate exists.
  assign cnt = st_q.cnt;
  assign irq = st_q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_zero_reload: assert property (@(posedge clk_sys) disable iff (!nrst)
    (underflow && !(wr.wr && !cfg.start)) |=> (st_q.cnt == $past(st_q.reload)) && irq)
    else $error("counter did not reload with interrupt at zero");

  chk_halt_hold: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!cfg.start && !wr.wr) |=> $stable(st_q.cnt))
    else $error("halted counter changed");

  chk_busy_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cfg.start && wr.wr && !tick) |=> $stable(st_q.cnt) && (st_q.reload == $past(wr.data)))
    else $error("running write touched the counter or missed reload");

  chk_halt_write: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!cfg.start && wr.wr) |=> (st_q.cnt == $past(wr.data)) && (st_q.reload == st_q.cnt))
    else $error("halted write did not load both registers");

  chk_count_down: assert property (@(posedge clk_sys) disable iff (!nrst)
    (tick && st_q.cnt != CNT_ZERO && !(wr.wr && !cfg.start))
      |=> st_q.cnt == $past(st_q.cnt) - 16'h0001)
    else $error("counter did not decrement");

  chk_edge_none: assert property (@(posedge clk_sys) disable iff (!nrst)
    (is_event && !alt_sel && cfg.mode[3:2] == 2'h3) |-> !tick)
    else $error("reserved edge code produced a count");

  chk_alt_source: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cfg.start && is_event && alt_sel) |-> (tick == alt_tick))
    else $error("substituted count source not followed");

endmodule : tpec_tmb_chan

// ### tpec_timer_top.sv
// Type-A pulse width modulator and three type-B timers with pin synchronisers.
`timescale 1ns/100ps
module tpec_timer_top
  import tpec_pkg::*;
(
  input  wire logic                     clk_sys,
  input  wire logic                     nrst,
  input  wire logic [NUM_SRC-1:0]       ce_src,
  input  wire logic                     ce_fc32,
  input  wire logic [NUM_TB:0]          start_flags,
  input  wire logic [7:0]               ta_mode,
  input  wire tpec_wr_t                 ta_wr,
  output logic [15:0]                   ta_rdata,
  input  wire logic                     timer_a_trigger_input,
  output logic                          timer_a_pulse_output,
  output logic                          ta_irq,
  input  wire logic [NUM_TB-1:0][7:0]   tb_mode,
  input  wire tpec_wr_t [NUM_TB-1:0]    tb_wr,
  output logic [NUM_TB-1:0][15:0]       tb_rdata,
  output logic [NUM_TB-1:0]             tb_irq,
  input  wire logic [NUM_TB-1:0]        timer_b_event_input,
  input  wire logic                     subclk_used,
  input  wire logic                     cascade_sel
);

  tpec_main_state_t st_q;
  tpec_main_state_t st_d;
  logic             pwm_mode;
  logic             pwm8;
  logic             ta_start;
  logic             trg_edge;
  logic             start_req;
  logic             ce_sel;
  logic             mod_tick;
  logic             psc_pulse;
  logic             wrap;
  logic [15:0]      last_pos;

  // ----------------------------------------------------------------
  // Type-A mode decode and trigger detection
  // ----------------------------------------------------------------
  always_comb begin
    pwm_mode = (ta_mode[2:0] == TA_MODE_PWM);
    pwm8     = ta_mode[MODE_PWM8_BIT];
    ta_start = start_flags[START_TA_BIT];
    ce_sel   = tpec_src_sel(ce_src, ta_mode);
    if (ta_mode[MODE_RISE_BIT]) begin
      trg_edge = st_q.trg_s2 & ~st_q.trg_prev;
    end else begin
      trg_edge = ~st_q.trg_s2 & st_q.trg_prev;
    end
    if (ta_mode[MODE_EXT_TRIG_BIT]) begin
      start_req = pwm_mode && ta_start && !st_q.run && trg_edge;
    end else begin
      start_req = pwm_mode && ta_start && !st_q.run;
    end
    psc_pulse = st_q.run && pwm8 && ce_sel && (st_q.psc == 8'h00);
    mod_tick  = pwm8 ? psc_pulse : (st_q.run && ce_sel);
    last_pos  = pwm8 ? {8'h00, PWM8_LAST} : PWM16_LAST;
    wrap      = mod_tick && (st_q.pos == last_pos);
  end

  // ----------------------------------------------------------------
  // Type-A modulator state
  // ----------------------------------------------------------------
  always_comb begin
    st_d          = st_q;
    st_d.trg_s1   = timer_a_trigger_input;
    st_d.trg_s2   = st_q.trg_s1;
    st_d.trg_prev = st_q.trg_s2;
    st_d.ev_s1    = timer_b_event_input;
    st_d.ev_s2    = st_q.ev_s1;
    st_d.irq      = 1'b0;
    if (ta_wr.wr) begin
      st_d.reload = ta_wr.data;
    end
    if (!st_q.run) begin
      if (ta_wr.wr) begin
        st_d.width = pwm8 ? {8'h00, ta_wr.data[15:8]} : ta_wr.data;
        st_d.psc   = ta_wr.data[7:0];
      end
      st_d.pos = 16'h0000;
      if (start_req) begin
        st_d.run = 1'b1;
      end
    end else if (!ta_start || !pwm_mode) begin
      st_d.run = 1'b0;
    end else begin
      // Triggers are not looked at here: a running modulator only counts.
      if (psc_pulse) begin
        st_d.psc = st_q.reload[7:0];
      end else if (pwm8 && ce_sel) begin
        st_d.psc = st_q.psc - 8'h01;
      end
      if (wrap) begin
        st_d.pos   = 16'h0000;
        st_d.width = pwm8 ? {8'h00, st_q.reload[15:8]} : st_q.reload;
      end else if (mod_tick) begin
        st_d.pos = st_q.pos + 16'h0001;
      end
    end
    st_d.out = st_d.run && (st_d.pos < st_d.width);
    if (st_q.run && st_d.run && st_q.out && !st_d.out) begin
      st_d.irq = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{trg_s1: 1'b0, trg_s2: 1'b0, trg_prev: 1'b0, run: 1'b0,
                reload: RELOAD_RST, pos: 16'h0000, width: RELOAD_RST,
                psc: 8'h00, out: 1'b0, irq: 1'b0,
                ev_s1: '0, ev_s2: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign timer_a_pulse_output = st_q.out;
  assign ta_irq               = st_q.irq;
  assign ta_rdata             = pwm_mode ? TA_UNDEF_READ : st_q.reload;

  // ----------------------------------------------------------------
  // Type-B timers
  // ----------------------------------------------------------------
  logic [NUM_TB-1:0] tb_alt_sel;
  logic [NUM_TB-1:0] tb_alt_tick;
  logic [NUM_TB-1:0] tb_uflow;

  always_comb begin
    tb_alt_sel           = '0;
    tb_alt_tick          = '0;
    tb_alt_sel[THIRD_B]  = subclk_used;
    tb_alt_tick[THIRD_B] = ce_fc32;
    tb_alt_sel[SECOND_B] = cascade_sel;
    tb_alt_tick[SECOND_B] = tb_uflow[THIRD_B];
  end

  generate
    for (genvar i = 0; i < NUM_TB; i++) begin : g_tb
      tpec_tmb_chan u_chan (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .cfg       ('{mode: tb_mode[i], start: start_flags[START_TB_LSB+i]}),
        .ce_src    (ce_src),
        .event_lvl (st_q.ev_s2[i]),
        .alt_sel   (tb_alt_sel[i]),
        .alt_tick  (tb_alt_tick[i]),
        .wr        (tb_wr[i]),
        .cnt       (tb_rdata[i]),
        .irq       (tb_irq[i]),
        .underflow (tb_uflow[i])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_out_halted: assert property (@(posedge clk_sys) disable iff (!nrst)
    !st_q.run |-> !timer_a_pulse_output)
    else $error("pulse output high while modulator halted");

  chk_sw_start: assert property (@(posedge clk_sys) disable iff (!nrst)
    (pwm_mode && !ta_mode[MODE_EXT_TRIG_BIT] && ta_start && !st_q.run) |=> st_q.run)
    else $error("software trigger did not start modulation");

  chk_ext_wait: assert property (@(posedge clk_sys) disable iff (!nrst)
    (ta_mode[MODE_EXT_TRIG_BIT] && !st_q.run && !trg_edge) |=> !st_q.run)
    else $error("external trigger mode started without an edge");

  chk_no_retrig: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_q.run && !mod_tick && ta_start && pwm_mode) |=> st_q.run && $stable(st_q.pos))
    else $error("running modulator reacted to a trigger");

  chk_fall_irq: assert property (@(posedge clk_sys) disable iff (!nrst)
    ($fell(st_q.out) && st_q.run) |-> ta_irq)
    else $error("no interrupt on falling pulse edge");

  chk_wrap_load: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wrap && !pwm8 && ta_start && pwm_mode && !ta_wr.wr)
      |=> (st_q.pos == 16'h0000) && (st_q.width == $past(st_q.reload)))
    else $error("width not reloaded before the next rise");

  chk_halt_load: assert property (@(posedge clk_sys) disable iff (!nrst)
    (!st_q.run && ta_wr.wr && !pwm8) |=> st_q.width == $past(ta_wr.data))
    else $error("halted write did not reach the counter");

  chk_read_undef: assert property (@(posedge clk_sys) disable iff (!nrst)
    pwm_mode |-> ta_rdata == TA_UNDEF_READ)
    else $error("modulation mode read returned counter data");

  chk_psc_reload: assert property (@(posedge clk_sys) disable iff (!nrst)
    (psc_pulse && ta_start && pwm_mode) |=> st_q.psc == $past(st_q.reload[7:0]))
    else $error("prescaler did not reload at zero");

  chk_psc_count: assert property (@(posedge clk_sys) disable iff (!nrst)
    (st_q.run && pwm8 && ce_sel && st_q.psc != 8'h00 && ta_start && pwm_mode)
      |=> st_q.psc == $past(st_q.psc) - 8'h01)
    else $error("prescaler did not count down");

  chk_wrap_load8: assert property (@(posedge clk_sys) disable iff (!nrst)
    (wrap && pwm8 && ta_start && pwm_mode)
      |=> (st_q.pos == 16'h0000) && (st_q.width == {8'h00, $past(st_q.reload[15:8])}))
    else $error("8-bit width not reloaded before the next rise");

  chk_pos_step: assert property (@(posedge clk_sys) disable iff (!nrst)
    (mod_tick && ta_start && pwm_mode && st_q.pos != last_pos)
      |=> st_q.pos == $past(st_q.pos) + 16'h0001)
    else $error("modulator position did not advance");

endmodule : tpec_timer_top

// ### tpec_pin_src.sv
// Pin-side model of the external trigger and event pulse sources.
`timescale 1ns/100ps
module tpec_pin_src
  import tpec_pkg::*;
(
  input  wire logic         clk_sys,
  output logic              trig_pin,
  output logic [NUM_TB-1:0] ev_pin
);
  initial begin
    trig_pin = 1'h0;
    ev_pin   = '0;
  end

  // Levels last several clocks so the two-stage synchronisers cannot miss them.
  task automatic trig_pulse();
    @(negedge clk_sys);
    trig_pin = 1'h1;
    repeat (4) @(negedge clk_sys);
    trig_pin = 1'h0;
    repeat (4) @(negedge clk_sys);
  endtask : trig_pulse

  task automatic ev_pulses(input int i, input int n);
    repeat (n) begin
      @(negedge clk_sys);
      ev_pin[i] = 1'h1;
      repeat (4) @(negedge clk_sys);
      ev_pin[i] = 1'h0;
      repeat (3) @(negedge clk_sys);
    end
    repeat (4) @(negedge clk_sys);
  endtask : ev_pulses
endmodule : tpec_pin_src

// ### tpec_timer_top_tb.sv
// Self-checking bench for the modulator and type-B timers.
`timescale 1ns/100ps
module tpec_timer_top_tb
  import tpec_pkg::*;
;
  logic                     clk_sys = 1'h0;
  logic                     nrst = 1'h0;
  logic [NUM_SRC-1:0]       ce_src;
  logic                     ce_fc32;
  logic [NUM_TB:0]          start_flags;
  logic [7:0]               ta_mode;
  tpec_wr_t                 ta_wr;
  logic [15:0]              ta_rdata;
  logic                     trig;
  logic                     ta_out;
  logic                     ta_irq;
  logic [NUM_TB-1:0][7:0]   tb_mode;
  tpec_wr_t [NUM_TB-1:0]    tb_wr;
  logic [NUM_TB-1:0][15:0]  tb_rdata;
  logic [NUM_TB-1:0]        tb_irq;
  logic [NUM_TB-1:0]        ev_pin;
  logic                     subclk_used;
  logic                     cascade_sel;
  int                       err_count = 0;
  int                       total_checks = 0;
  int                       hi;
  int                       ia;
  int                       ib;

  always #25 clk_sys = ~clk_sys;

  tpec_timer_top dut (
    .clk_sys(clk_sys), .nrst(nrst), .ce_src(ce_src), .ce_fc32(ce_fc32),
    .start_flags(start_flags), .ta_mode(ta_mode), .ta_wr(ta_wr), .ta_rdata(ta_rdata),
    .timer_a_trigger_input(trig), .timer_a_pulse_output(ta_out), .ta_irq(ta_irq),
    .tb_mode(tb_mode), .tb_wr(tb_wr), .tb_rdata(tb_rdata), .tb_irq(tb_irq),
    .timer_b_event_input(ev_pin), .subclk_used(subclk_used), .cascade_sel(cascade_sel)
  );

  tpec_pin_src src (.clk_sys(clk_sys), .trig_pin(trig), .ev_pin(ev_pin));

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic chkn(input string nm, input int e, input int g);
    total_checks++;
    if (g != e) begin
      err_count++;
      $display("unexpected %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chkn

  task automatic results();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results

  // Counts output high cycles and interrupt pulses over n settled samples.
  task automatic meas(input int n);
    hi = 0;
    ia = 0;
    ib = 0;
    repeat (n) begin
      @(negedge clk_sys);
      hi += int'(ta_out === 1'h1);
      ia += int'(ta_irq === 1'h1);
      ib += int'(tb_irq[0] === 1'h1);
    end
  endtask : meas

  task automatic wa(input logic [15:0] d);
    @(negedge clk_sys);
    ta_wr = '{1'h1, d};
    @(negedge clk_sys);
    ta_wr.wr = 1'h0;
  endtask : wa

  task automatic wb(input int i, input logic [15:0] d);
    @(negedge clk_sys);
    tb_wr[i] = '{1'h1, d};
    @(negedge clk_sys);
    tb_wr[i].wr = 1'h0;
  endtask : wb

  task automatic t_pwm16();
    ta_mode = 8'h07;
    wa(16'h0003);
    chk("ta_rdata", TA_UNDEF_READ, ta_rdata);
    start_flags[START_TA_BIT] = 1'h1;
    meas(10);
    chkn("pwm16 high", 3, hi);
    chkn("pwm16 irq", 1, ia);
    wa(16'h0005);
    meas(65560);
    chkn("pwm16 new high", 5, hi);
    chkn("pwm16 period irq", 1, ia);
    start_flags[START_TA_BIT] = 1'h0;
  endtask : t_pwm16

  task automatic t_pwm8();
    ta_mode = 8'h7F;
    wa(16'h0201);
    start_flags[START_TA_BIT] = 1'h1;
    meas(30);
    chkn("pwm8 idle high", 0, hi);
    fork
      begin
        src.trig_pulse();
        repeat (100) @(negedge clk_sys);
        src.trig_pulse();
      end
      meas(1000);
    join
    chkn("pwm8 high", 8, hi);
    chkn("pwm8 irq", 2, ia);
    start_flags[START_TA_BIT] = 1'h0;
    ta_mode = 8'h77;
    wa(16'h0201);
    start_flags[START_TA_BIT] = 1'h1;
    fork
      src.trig_pulse();
      begin
        meas(6);
        chkn("pwm8 rise ignored", 0, hi);
        meas(14);
        chkn("pwm8 fall start", 4, hi);
      end
    join
    start_flags[START_TA_BIT] = 1'h0;
  endtask : t_pwm8

  task automatic t_btimer();
    logic [15:0] v;
    tb_mode[0] = {6'h00, TB_MODE_TIMER};
    wb(0, 16'h0002);
    chk("tb0 load", 16'h0002, tb_rdata[0]);
    start_flags[START_TB_LSB] = 1'h1;
    meas(30);
    chkn("tb0 irq", 10, ib);
    for (int k = 0; k < 3 && tb_rdata[0] !== 16'h0002; k++) @(negedge clk_sys);
    chk("tb0 reloaded", 16'h0002, tb_rdata[0]);
    wb(0, 16'h0009);
    chk("tb0 busy write", 16'h0000, tb_rdata[0]);
    start_flags[START_TB_LSB] = 1'h0;
    meas(2);
    v = tb_rdata[0];
    meas(20);
    chkn("tb0 halted irq", 0, ib);
    chk("tb0 halted cnt", v, tb_rdata[0]);
    start_flags[START_TB_LSB] = 1'h1;
    @(negedge clk_sys);
    chk("tb0 next reload", 16'h0009, tb_rdata[0]);
    chk("tb0 reload irq", {15'h0000, tb_irq[0]}, 16'h0001);
    tb_mode[0] = {2'h2, 4'h0, TB_MODE_TIMER};
    ce_src = 4'hB;
    meas(5);
    chk("tb0 source gated", 16'h0009, tb_rdata[0]);
    ce_src = '1;
    @(negedge clk_sys);
    chk("tb0 source counts", 16'h0008, tb_rdata[0]);
    start_flags[START_TB_LSB] = 1'h0;
  endtask : t_btimer

  task automatic t_bevent();
    logic [1:0] codes[4] = '{TB_EDGE_FALL, TB_EDGE_RISE, TB_EDGE_BOTH, 2'h3};
    int         nexp[4] = '{4, 4, 8, 0};
    for (int k = 0; k < 4; k++) begin
      tb_mode[SECOND_B] = {4'h0, codes[k], TB_MODE_EVENT};
      wb(SECOND_B, 16'h0100);
      start_flags[START_TB_LSB+SECOND_B] = 1'h1;
      src.ev_pulses(SECOND_B, 4);
      start_flags[START_TB_LSB+SECOND_B] = 1'h0;
      src.ev_pulses(SECOND_B, 2);
      chk("tb1 events", 16'h0100 - 16'(nexp[k]), tb_rdata[SECOND_B]);
    end
  endtask : t_bevent

  task automatic t_bsub();
    tb_mode[SECOND_B] = {6'h00, TB_MODE_EVENT};
    tb_mode[THIRD_B] = {6'h00, TB_MODE_EVENT};
    wb(SECOND_B, 16'h0010);
    wb(THIRD_B, 16'h0001);
    subclk_used = 1'h1;
    cascade_sel = 1'h1;
    start_flags[NUM_TB:START_TB_LSB+SECOND_B] = 2'h3;
    fork
      repeat (6) begin
        @(negedge clk_sys);
        ce_fc32 = 1'h1;
        @(negedge clk_sys);
        ce_fc32 = 1'h0;
      end
      src.ev_pulses(SECOND_B, 3);
      src.ev_pulses(THIRD_B, 3);
    join
    meas(4);
    chk("tb2 clock timer", 16'h0001, tb_rdata[THIRD_B]);
    chk("tb1 cascade", 16'h000D, tb_rdata[SECOND_B]);
  endtask : t_bsub

  initial begin
    ce_src = '1;
    ce_fc32 = 1'h0;
    start_flags = '0;
    ta_mode = 8'h00;
    ta_wr = '0;
    tb_mode = '0;
    tb_wr = '0;
    subclk_used = 1'h0;
    cascade_sel = 1'h0;
    repeat (8) @(negedge clk_sys);
    nrst = 1'h1;
    t_pwm16();
    t_pwm8();
    t_btimer();
    t_bevent();
    t_bsub();
    results();
  end

  initial begin
    repeat (95000) @(posedge clk_sys);
    err_count++;
    $display("unexpected run length expected done seen hang");
    results();
  end
endmodule : tpec_timer_top_tb
